//--- rcd_pkg.sv
// Shared constants for the completion descriptor framer and its consumer
package rcd_pkg;
	// Descriptor layout
	localparam int DESC_W = 96;
	localparam int DESC_DW = 3;
	localparam int LOW_ADDR_LSB = 0;
	localparam int LOW_ADDR_W = 12;
	localparam int ERR_LSB = 12;
	localparam int ERR_W = 4;
	localparam int BCNT_LSB = 16;
	localparam int BCNT_W = 13;
	localparam int LOCKED_BIT = 29;
	localparam int DONE_BIT = 30;
	localparam int DWCNT_LSB = 32;
	localparam int DWCNT_W = 11;
	localparam int STATUS_LSB = 43;
	localparam int STATUS_W = 3;
	localparam int POISON_BIT = 46;
	localparam int REQID_LSB = 48;
	localparam int TAG_LSB = 64;
	localparam int CPLID_LSB = 72;
	localparam int TC_LSB = 89;
	localparam int ATTR_LSB = 92;
	localparam int ID_W = 16;
	localparam int TAG_W = 8;
	localparam int TC_W = 3;
	localparam int ATTR_W = 3;
	// Attribute bits inside the attribute field
	localparam int ATTR_NO_SNOOP = 0;
	localparam int ATTR_RELAXED = 1;
	localparam int ATTR_ID_ORDER = 2;
	// Completion status codes
	localparam logic [2:0] STATUS_SC = 3'h0;
	localparam logic [2:0] STATUS_UR = 3'h1;
	localparam logic [2:0] STATUS_CRS = 3'h2;
	localparam logic [2:0] STATUS_CA = 3'h4;
	// Error codes
	localparam logic [3:0] ERR_NORMAL = 4'h0;
	localparam logic [3:0] ERR_POISONED = 4'h1;
	localparam logic [3:0] ERR_TIMEOUT = 4'h9;
	// Dword counts forced for special completions
	localparam logic [10:0] DWCNT_ONE = 11'h001;
	localparam logic [10:0] DWCNT_ZERO = 11'h000;
	// Stream shape
	localparam int DATA_W_DEF = 64;
	localparam int FIFO_DEPTH_DEF = 32;
	localparam int SB_W = 8;
	localparam int SOF_BIT = 0;
	// Kind of completed request
	typedef enum logic [1:0] {
		KIND_MEM_READ,
		KIND_MEM_READ_ZERO,
		KIND_IO_READ,
		KIND_IO_WRITE
	} rcd_kind_t;
endpackage

//--- rcd_rc_if.sv
// Completion stream between the framer and the consuming user logic
`timescale 1ns/1ps
interface rcd_rc_if #(
	parameter int DATA_W = rcd_pkg::DATA_W_DEF
);
	logic [DATA_W-1:0] tdata;
	logic [DATA_W/32-1:0] tkeep;
	logic tlast;
	logic tvalid;
	logic tready;
	logic [rcd_pkg::SB_W-1:0] completion_sideband_bus;

	modport dev (
		output tdata,
		output tkeep,
		output tlast,
		output tvalid,
		output completion_sideband_bus,
		input tready
	);
	modport usr (
		input tdata,
		input tkeep,
		input tlast,
		input tvalid,
		input completion_sideband_bus,
		output tready
	);
endinterface // rcd_rc_if

//--- rcd_framer.sv
// Descriptor FIFO and requester completion framer, device end
// Behaviour
// - bit 30 marks final completion of request
// - user holds tag until completed descriptor
// - bits 42:32 give payload dword count
// - count 1 for I/O read, zero-length; 0 I/O write
// - bits 45:43 carry completion status
// - bit 46 flags poisoned completion data
// - bits 63:48 carry requester ID
// - bits 71:64 carry tag
// - bits 87:72 carry completer ID
// - bits 91:89 carry traffic class
// - bits 94:92 carry attributes
// - one beat at 128/256, two at 64
// - tvalid held across all beats of packet
// - beat held until user accepts it
// - tkeep contiguous over descriptor dwords
// - tkeep low only in final beat
// - tlast exactly on last beat
// - first-beat flag on every first beat
// - user ignores other sideband bits
// - descriptor is three leading dwords
// - bits 15:12 carry error code
`timescale 1ns/1ps
module rcd_fifo #(
	parameter int WIDTH = rcd_pkg::DESC_W,
	parameter int DEPTH = rcd_pkg::FIFO_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int IW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [IW-1:0] wr;
		logic [IW-1:0] rd;
		logic [CW-1:0] count;
	} rcd_fifo_st_t;

	rcd_fifo_st_t st_reg;
	rcd_fifo_st_t st_next;
	logic push;
	logic pop;

	// Honest flags straight from the occupancy count
	assign in_ready = (st_reg.count != CW'(DEPTH));
	assign out_valid = (st_reg.count != '0);
	assign out_data = st_reg.mem[st_reg.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr] = in_data;
			st_next.wr = (st_reg.wr == IW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
		end
		if (pop) begin
			st_next.rd = (st_reg.rd == IW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
		end
		case ({push, pop})
			2'b10: st_next.count = st_reg.count + 1'b1;
			2'b01: st_next.count = st_reg.count - 1'b1;
			default: st_next.count = st_reg.count;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // rcd_fifo

module rcd_framer #(
	parameter int DATA_W = rcd_pkg::DATA_W_DEF,
	parameter int FIFO_DEPTH = rcd_pkg::FIFO_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cpl_valid,
	output logic cpl_ready,
	input wire rcd_pkg::rcd_kind_t cpl_kind,
	input wire logic [10:0] cpl_payload_dwords,
	input wire logic [11:0] cpl_lower_addr,
	input wire logic [3:0] cpl_error_code,
	input wire logic [12:0] cpl_byte_count,
	input wire logic cpl_locked,
	input wire logic cpl_request_done,
	input wire logic [2:0] cpl_status,
	input wire logic cpl_poisoned,
	input wire logic [15:0] cpl_requester_id,
	input wire logic [7:0] cpl_tag,
	input wire logic [15:0] cpl_completer_id,
	input wire logic [2:0] cpl_tc,
	input wire logic [2:0] cpl_attr,
	rcd_rc_if.dev rc
);
	localparam int KW = DATA_W / 32;
	localparam int EXT_W = 2 * DATA_W;
	localparam int NB = (rcd_pkg::DESC_W + DATA_W - 1) / DATA_W;

	typedef struct packed {
		logic valid;
		logic beat;
		logic last;
		logic sof;
		logic [rcd_pkg::DESC_W-1:0] desc;
		logic [DATA_W-1:0] data;
		logic [KW-1:0] keep;
	} rcd_frm_st_t;

	rcd_frm_st_t st_reg;
	rcd_frm_st_t st_next;
	logic [rcd_pkg::DESC_W-1:0] desc_in;
	logic [rcd_pkg::DESC_W-1:0] desc_q;
	logic [10:0] dw_count;
	logic q_valid;
	logic q_pop;
	logic take;

	// Slice of the descriptor carried by a beat
	function automatic logic [DATA_W-1:0] beat_word(
		input logic [rcd_pkg::DESC_W-1:0] d,
		input logic b
	);
		logic [EXT_W-1:0] ext;
		ext = EXT_W'(d);
		return b ? ext[EXT_W-1:DATA_W] : ext[DATA_W-1:0];
	endfunction

	// Dword positions filled in a beat, contiguous from lane 0
	function automatic logic [KW-1:0] beat_keep(input logic b);
		int n;
		n = rcd_pkg::DESC_DW - (b ? KW : 0);
		if (n > KW) begin
			n = KW;
		end
		return ~({KW{1'b1}} << n);
	endfunction

	// Dword count forced for I/O and zero-length reads
	always_comb begin
		unique case (cpl_kind)
			rcd_pkg::KIND_IO_READ: dw_count = rcd_pkg::DWCNT_ONE;
			rcd_pkg::KIND_MEM_READ_ZERO: dw_count = rcd_pkg::DWCNT_ONE;
			rcd_pkg::KIND_IO_WRITE: dw_count = rcd_pkg::DWCNT_ZERO;
			rcd_pkg::KIND_MEM_READ: dw_count = cpl_payload_dwords;
		endcase
	end

	// Descriptor assembly, unused bits left zero
	always_comb begin
		desc_in = '0;
		desc_in[rcd_pkg::LOW_ADDR_LSB +: rcd_pkg::LOW_ADDR_W] = cpl_lower_addr;
		desc_in[rcd_pkg::ERR_LSB +: rcd_pkg::ERR_W] = cpl_error_code;
		desc_in[rcd_pkg::BCNT_LSB +: rcd_pkg::BCNT_W] = cpl_byte_count;
		desc_in[rcd_pkg::LOCKED_BIT] = cpl_locked;
		desc_in[rcd_pkg::DONE_BIT] = cpl_request_done;
		desc_in[rcd_pkg::DWCNT_LSB +: rcd_pkg::DWCNT_W] = dw_count;
		desc_in[rcd_pkg::STATUS_LSB +: rcd_pkg::STATUS_W] = cpl_status;
		desc_in[rcd_pkg::POISON_BIT] = cpl_poisoned;
		desc_in[rcd_pkg::REQID_LSB +: rcd_pkg::ID_W] = cpl_requester_id;
		desc_in[rcd_pkg::TAG_LSB +: rcd_pkg::TAG_W] = cpl_tag;
		desc_in[rcd_pkg::CPLID_LSB +: rcd_pkg::ID_W] = cpl_completer_id;
		desc_in[rcd_pkg::TC_LSB +: rcd_pkg::TC_W] = cpl_tc;
		desc_in[rcd_pkg::ATTR_LSB +: rcd_pkg::ATTR_W] = cpl_attr;
	end

	// Descriptor queue; a full queue stalls the source
	rcd_fifo #(
		.WIDTH(rcd_pkg::DESC_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(cpl_valid),
		.in_ready(cpl_ready),
		.in_data(desc_in),
		.out_valid(q_valid),
		.out_ready(q_pop),
		.out_data(desc_q)
	);

	assign take = st_reg.valid && rc.tready;

	// Beat sequencer: load a packet, step beats, hold while stalled
	always_comb begin
		st_next = st_reg;
		q_pop = 1'b0;
		if (!st_reg.valid || (take && st_reg.last)) begin
			st_next.valid = q_valid;
			q_pop = q_valid;
			st_next.desc = desc_q;
			st_next.beat = 1'b0;
			st_next.sof = 1'b1;
			st_next.last = (NB == 1);
			st_next.data = beat_word(desc_q, 1'b0);
			st_next.keep = beat_keep(1'b0);
		end else if (take) begin
			st_next.beat = 1'b1;
			st_next.sof = 1'b0;
			st_next.last = 1'b1;
			st_next.data = beat_word(st_reg.desc, 1'b1);
			st_next.keep = beat_keep(1'b1);
		end
		// Otherwise the beat stays on the bus unchanged
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Stream outputs straight from state flops
	assign rc.tvalid = st_reg.valid;
	assign rc.tdata = st_reg.data;
	assign rc.tkeep = st_reg.keep;
	assign rc.tlast = st_reg.last;
	always_comb begin
		rc.completion_sideband_bus = '0;
		rc.completion_sideband_bus[rcd_pkg::SOF_BIT] = st_reg.sof;
	end
endmodule // rcd_framer

//--- rcd_consumer.sv
// User logic end: collects completion descriptors and tracks tags
`timescale 1ns/1ps
module rcd_consumer #(
	parameter int DATA_W = rcd_pkg::DATA_W_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	rcd_rc_if.usr rc,
	input wire logic ari_mode,
	output logic desc_valid,
	input wire logic desc_ready,
	output logic [11:0] desc_lower_addr,
	output logic [3:0] desc_error_code,
	output logic [12:0] desc_byte_count,
	output logic desc_locked,
	output logic desc_request_done,
	output logic [10:0] desc_dword_count,
	output logic [2:0] desc_status,
	output logic desc_data_corrupt,
	output logic [15:0] desc_requester_id,
	output logic [7:0] desc_tag,
	output logic [7:0] desc_cpl_bus,
	output logic [4:0] desc_cpl_dev,
	output logic [7:0] desc_cpl_fn,
	output logic [2:0] desc_tc,
	output logic desc_no_snoop,
	output logic desc_relaxed,
	output logic desc_id_order,
	input wire logic alloc_valid,
	input wire logic [7:0] alloc_tag,
	input wire logic [7:0] query_tag,
	output logic tag_busy
);
	localparam int EXT_W = 2 * DATA_W;
	localparam int NTAG = 256;

	typedef struct packed {
		logic out_valid;
		logic [rcd_pkg::DESC_W-1:0] desc;
		logic [NTAG-1:0] busy;
	} rcd_usr_st_t;

	rcd_usr_st_t st_reg;
	rcd_usr_st_t st_next;
	logic [EXT_W-1:0] ext;
	logic [rcd_pkg::DESC_W-1:0] acc;
	logic beat_ok;
	logic sof;

	// Only the first-beat flag is looked at in the sideband
	assign sof = rc.completion_sideband_bus[rcd_pkg::SOF_BIT];
	// Stall the stream while a descriptor waits
	assign rc.tready = !st_reg.out_valid;
	assign beat_ok = rc.tvalid && rc.tready;
	assign ext = EXT_W'(rc.tdata);

	// Collect beats; a first beat restarts the descriptor
	always_comb begin
		st_next = st_reg;
		acc = rcd_pkg::DESC_W'(ext);
		if (!sof) begin
			acc = st_reg.desc | rcd_pkg::DESC_W'(ext << DATA_W);
		end
		if (st_reg.out_valid && desc_ready) begin
			st_next.out_valid = 1'b0;
		end
		if (beat_ok) begin
			st_next.desc = acc;
			if (rc.tlast) begin
				st_next.out_valid = 1'b1;
				// Completed request frees its tag
				if (acc[rcd_pkg::DONE_BIT]) begin
					st_next.busy[acc[rcd_pkg::TAG_LSB +: rcd_pkg::TAG_W]] = 1'b0;
				end
			end
		end
		// Allocation after the clear so a new claim wins
		if (alloc_valid) begin
			st_next.busy[alloc_tag] = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Field outputs sliced from the held descriptor
	assign desc_valid = st_reg.out_valid;
	assign tag_busy = st_reg.busy[query_tag];
	assign desc_lower_addr = st_reg.desc[rcd_pkg::LOW_ADDR_LSB +:
		rcd_pkg::LOW_ADDR_W];
	assign desc_error_code = st_reg.desc[rcd_pkg::ERR_LSB +: rcd_pkg::ERR_W];
	assign desc_byte_count = st_reg.desc[rcd_pkg::BCNT_LSB +: rcd_pkg::BCNT_W];
	assign desc_locked = st_reg.desc[rcd_pkg::LOCKED_BIT];
	assign desc_request_done = st_reg.desc[rcd_pkg::DONE_BIT];
	assign desc_dword_count = st_reg.desc[rcd_pkg::DWCNT_LSB +:
		rcd_pkg::DWCNT_W];
	assign desc_status = st_reg.desc[rcd_pkg::STATUS_LSB +: rcd_pkg::STATUS_W];
	assign desc_data_corrupt = st_reg.desc[rcd_pkg::POISON_BIT];
	assign desc_requester_id = st_reg.desc[rcd_pkg::REQID_LSB +: rcd_pkg::ID_W];
	assign desc_tag = st_reg.desc[rcd_pkg::TAG_LSB +: rcd_pkg::TAG_W];
	assign desc_tc = st_reg.desc[rcd_pkg::TC_LSB +: rcd_pkg::TC_W];
	assign desc_no_snoop = st_reg.desc[rcd_pkg::ATTR_LSB +
		rcd_pkg::ATTR_NO_SNOOP];
	assign desc_relaxed = st_reg.desc[rcd_pkg::ATTR_LSB +
		rcd_pkg::ATTR_RELAXED];
	assign desc_id_order = st_reg.desc[rcd_pkg::ATTR_LSB +
		rcd_pkg::ATTR_ID_ORDER];

	// Completer ID split, legacy or ARI
	always_comb begin
		desc_cpl_bus = st_reg.desc[rcd_pkg::CPLID_LSB + 8 +: 8];
		if (ari_mode) begin
			desc_cpl_dev = 5'h00;
			desc_cpl_fn = st_reg.desc[rcd_pkg::CPLID_LSB +: 8];
		end else begin
			desc_cpl_dev = st_reg.desc[rcd_pkg::CPLID_LSB + 3 +: 5];
			desc_cpl_fn = {5'h00, st_reg.desc[rcd_pkg::CPLID_LSB +: 3]};
		end
	end
endmodule // rcd_consumer

//--- rcd_rc_chk.sv
// Protocol checker for the completion descriptor stream
`timescale 1ns/1ps
module rcd_rc_chk #(
	parameter int DATA_W = 64
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [DATA_W-1:0] tdata,
	input wire logic [DATA_W/32-1:0] tkeep,
	input wire logic tlast,
	input wire logic tvalid,
	input wire logic tready,
	input wire logic [7:0] completion_sideband_bus
);
	// One clock domain for every property
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic sof = completion_sideband_bus[0];

	// Stalled beat stays on the wires
	property p_hold;
		tvalid && !tready |=> tvalid && $stable(tdata) && $stable(tkeep)
			&& $stable(tlast) && $stable(sof);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stalled beat changed");
	// Accepted first beat is followed at once by the last
	property p_sof_beat;
		tvalid && tready && sof |=> tvalid && tlast && !sof;
	endproperty
	a_sof_beat: assert property (p_sof_beat)
		else $error("no-data packet not two beats");
	// First beat carries two full dwords
	property p_first_shape;
		tvalid && sof |-> tkeep == 2'h3 && !tlast;
	endproperty
	a_first_shape: assert property (p_first_shape)
		else $error("first beat shape wrong");
	// Last beat carries only the third descriptor dword
	property p_last_shape;
		tvalid && tlast |-> tkeep == 2'h1 && tdata[63:32] == 32'h0;
	endproperty
	a_last_shape: assert property (p_last_shape)
		else $error("last beat shape wrong");
	// Unused descriptor bits 88 and 95 stay low in the last beat
	property p_rsvd_zero;
		tvalid && tlast |-> !tdata[24] && !tdata[31];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("unused descriptor bit set");
	// A packet opens with the first-beat flag
	property p_start_flag;
		$rose(tvalid) |-> sof;
	endproperty
	a_start_flag: assert property (p_start_flag)
		else $error("packet start without flag");
	// After a last beat comes idle or a new packet
	property p_after_last;
		tvalid && tready && tlast |=> !tvalid || sof;
	endproperty
	a_after_last: assert property (p_after_last)
		else $error("beat after last not a start");
	// Dword count within its legal range
	property p_dw_range;
		tvalid && sof |-> tdata[42:32] <= 11'h400;
	endproperty
	a_dw_range: assert property (p_dw_range)
		else $error("dword count out of range");

	// Main scenarios
	c_stall: cover property (tvalid && !tready);
	c_packet: cover property (tvalid && tready && sof ##1 tready && tlast);
	c_idle: cover property (tvalid && tready && tlast ##1 !tvalid);
endmodule // rcd_rc_chk

//--- tb_top.sv
// Self-checking bench for the framer and consumer pair
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		rcd_pkg::rcd_kind_t k;
		logic [10:0] pd;
		logic [7:0] tg;
		logic [2:0] st;
		logic [2:0] at;
		logic dn;
		logic ps;
	} rcd_tb_req_t;
	localparam logic [2:0] ST_TAB [4] = '{rcd_pkg::STATUS_SC,
		rcd_pkg::STATUS_UR, rcd_pkg::STATUS_CRS, rcd_pkg::STATUS_CA};
	localparam logic [2:0] AT_TAB [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
	logic clk = 1'b0, reset_n = 1'b0, cpl_valid = 1'b0, cpl_ready, b;
	logic ari_mode = 1'b0, desc_ready = 1'b0, alloc_valid = 1'b0;
	logic [7:0] alloc_tag = 8'h00, query_tag = 8'h00;
	logic desc_valid, desc_locked, desc_request_done, desc_data_corrupt;
	logic desc_no_snoop, desc_relaxed, desc_id_order, tag_busy;
	logic [2:0] desc_status, desc_tc;
	logic [3:0] desc_error_code;
	logic [4:0] desc_cpl_dev;
	logic [7:0] desc_tag, desc_cpl_bus, desc_cpl_fn;
	logic [10:0] desc_dword_count;
	logic [11:0] desc_lower_addr;
	logic [12:0] desc_byte_count;
	logic [15:0] desc_requester_id;
	int error_cnt = 0, samples_checked = 0;
	rcd_tb_req_t cur = '0, q[$];

	rcd_rc_if #(.DATA_W(64)) rc_i ();
	// Other fields follow the tag, and TC the attributes, so that each packet differs
	rcd_framer rcd_framer_i (
		.clk, .reset_n, .cpl_valid, .cpl_ready, .cpl_kind(cur.k),
		.cpl_payload_dwords(cur.pd), .cpl_lower_addr({4'h3, cur.tg}),
		.cpl_error_code(cur.tg[3:0]), .cpl_byte_count({5'h01, cur.tg}),
		.cpl_locked(cur.tg[0]), .cpl_request_done(cur.dn),
		.cpl_status(cur.st), .cpl_poisoned(cur.ps),
		.cpl_requester_id({8'ha5, cur.tg}),
		.cpl_completer_id({~cur.tg, cur.tg}), .cpl_tag(cur.tg),
		.cpl_tc(cur.at ^ 3'h5), .cpl_attr(cur.at), .rc(rc_i)
	);
	rcd_consumer rcd_consumer_i (
		.clk, .reset_n, .rc(rc_i), .ari_mode, .desc_valid, .desc_ready,
		.desc_lower_addr, .desc_error_code, .desc_byte_count, .desc_locked,
		.desc_request_done, .desc_dword_count, .desc_status,
		.desc_data_corrupt, .desc_requester_id, .desc_tag, .desc_cpl_bus,
		.desc_cpl_dev, .desc_cpl_fn, .desc_tc, .desc_no_snoop,
		.desc_relaxed, .desc_id_order, .alloc_valid, .alloc_tag,
		.query_tag, .tag_busy
	);
	rcd_rc_chk #(.DATA_W(64)) rcd_rc_chk_i (
		.clk, .reset_n, .tdata(rc_i.tdata), .tkeep(rc_i.tkeep),
		.tlast(rc_i.tlast), .tvalid(rc_i.tvalid), .tready(rc_i.tready),
		.completion_sideband_bus(rc_i.completion_sideband_bus)
	);

	// Clock of 50 ns
	always #25 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Offers one completion and waits until it is taken
	task automatic push(input rcd_tb_req_t r);
		int n;
		n = 0;
		cur = r;
		cpl_valid = 1'b1;
		while (cpl_ready !== 1'b1 && n < 200) begin
			@(posedge clk) #1;
			n++;
		end
		// A queue that never frees up counts as a mismatch
		if (n >= 200) begin
			error_cnt++;
			$display("Error at %0t: completion never accepted", $time);
		end
		@(posedge clk) #1;
		q.push_back(r);
	endtask

	// Waits for a descriptor, compares it, then releases it
	task automatic pop();
		rcd_tb_req_t r;
		logic [10:0] dw;
		logic [20:0] cid;
		int n;
		n = 0;
		while (desc_valid !== 1'b1 && n < 200) begin
			@(posedge clk) #1;
			n++;
		end
		// A descriptor that never shows up counts as a mismatch
		if (n >= 200) begin
			error_cnt++;
			$display("Error at %0t: descriptor never delivered", $time);
		end
		r = q.pop_front();
		dw = r.k == rcd_pkg::KIND_MEM_READ ? r.pd :
			r.k == rcd_pkg::KIND_IO_WRITE ? rcd_pkg::DWCNT_ZERO : rcd_pkg::DWCNT_ONE;
		cid = ari_mode ? {~r.tg, 5'h00, r.tg} : {~r.tg, r.tg[7:3], 5'h00, r.tg[2:0]};
		chk(desc_dword_count, dw);
		chk(desc_status, r.st);
		chk(desc_data_corrupt, r.ps);
		chk(desc_requester_id, {8'ha5, r.tg});
		chk(desc_tag, r.tg);
		chk({desc_cpl_bus, desc_cpl_dev, desc_cpl_fn}, cid);
		chk(desc_tc, r.at ^ 3'h5);
		chk({desc_id_order, desc_relaxed, desc_no_snoop}, r.at);
		chk(desc_request_done, r.dn);
		chk(desc_error_code, r.tg[3:0]);
		chk({desc_lower_addr, desc_byte_count, desc_locked},
			{4'h3, r.tg, 5'h01, r.tg, r.tg[0]});
		desc_ready = 1'b1;
		@(posedge clk) #1;
		desc_ready = 1'b0;
	endtask

	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Wire shape of each accepted beat
	wire logic [10:0] shape = {rc_i.completion_sideband_bus, rc_i.tlast,
		rc_i.tkeep};
	always @(negedge clk) begin
		if (!reset_n)
			b <= 1'b0;
		else if (rc_i.tvalid && rc_i.tready) begin
			chk(shape, b ? 11'h005 : 11'h00b);
			if (b) begin
				chk(rc_i.tdata[63:32], 32'h0);
				chk({rc_i.tdata[31], rc_i.tdata[24]}, 2'h0);
			end
			b <= ~b;
		end
	end

	// Main sequence
	initial begin
		int n;
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		// Every kind, status and attribute, back to back
		for (int i = 0; i < 4; i++)
			push('{rcd_pkg::rcd_kind_t'(i), 11'h005 + 11'(i), 8'h10 + 8'(i),
				ST_TAB[i], AT_TAB[i], i[0], i[1]});
		cpl_valid = 1'b0;
		repeat (4) pop();
		// Fill with the consumer stalled, then drain in order
		n = 0;
		while (cpl_ready === 1'b1 && n < 40) begin
			push('{rcd_pkg::KIND_MEM_READ, 11'(n), 8'h40 + 8'(n), 3'h0, 3'h2,
				1'b1, 1'b0});
			n++;
		end
		cpl_valid = 1'b0;
		chk({cpl_ready, n >= 32}, 2'h1);
		repeat (n) pop();
		// Completer number split in ARI mode
		ari_mode = 1'b1;
		push('{rcd_pkg::KIND_IO_READ, 11'h000, 8'h9a, 3'h1, 3'h0, 1'b1, 1'b1});
		cpl_valid = 1'b0;
		pop();
		ari_mode = 1'b0;
		// Tag stays busy until its final completion
		alloc_tag = 8'h21;
		query_tag = 8'h21;
		alloc_valid = 1'b1;
		@(posedge clk) #1;
		alloc_valid = 1'b0;
		chk(tag_busy, 1'b1);
		push('{rcd_pkg::KIND_IO_WRITE, 11'h000, 8'h21, 3'h0, 3'h0, 1'b0, 1'b0});
		cpl_valid = 1'b0;
		pop();
		chk(tag_busy, 1'b1);
		push('{rcd_pkg::KIND_MEM_READ_ZERO, 11'h000, 8'h21, 3'h4, 3'h1, 1'b1,
			1'b0});
		cpl_valid = 1'b0;
		pop();
		chk(tag_busy, 1'b0);
		end_of_test();
	end

	// Cuts a hang short
	initial begin
		#250000;
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule // tb_top
